// >>> tmc_pkg.sv
/*
  shared constants and carrier types of the dual timer/counter.
  assumes one clock domain; the top module and its two helpers import it.
*/
`default_nettype none

package tmc_pkg;

  // ==========================================================
  // sizes and timing
  localparam int          TMC_TIMERS    = 2;      // timer 0 and timer 1
  localparam int          TMC_MC_CLKS   = 2;      // cpu clocks per machine cycle
  localparam int          TMC_PWM_COUNT = 256;    // pwm period in timer clocks

  // ==========================================================
  // mode codes
  localparam logic [2:0]  TMC_MODE_13BIT  = 3'h0;
  localparam logic [2:0]  TMC_MODE_16BIT  = 3'h1;
  localparam logic [2:0]  TMC_MODE_RELOAD = 3'h2;
  localparam logic [2:0]  TMC_MODE_SPLIT  = 3'h3;
  localparam logic [2:0]  TMC_MODE_PWM    = 3'h6;

  // ==========================================================
  // field limits and reset values
  localparam logic [4:0]  TMC_PRESC_MAX = 5'h1f;   // top of the divide-by-32 part
  localparam logic [7:0]  TMC_BYTE_MAX  = 8'hff;
  localparam logic [15:0] TMC_WORD_MAX  = 16'hffff;
  localparam logic [15:0] TMC_COUNT_RST = 16'h0000;
  localparam logic [7:0]  TMC_BAUD_RST  = 8'h00;
  localparam logic        TMC_FLAG_RST  = 1'b0;
  localparam logic        TMC_PIN_RST   = 1'b1;    // idle pin level
  localparam logic        TMC_OE_RST    = 1'b0;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic       run;          // count enable
    logic       counter_sel;  // 1: count pin falls, 0: machine cycles
    logic [2:0] mode;         // one of the mode codes
    logic       toggle_en;    // drive the pin, toggle on overflow
  } tmc_ctrl_type;

  typedef struct packed {
    logic        stb;         // one-cycle write of the count register
    logic [15:0] value;
  } tmc_load_type;

endpackage

`default_nettype wire

// >>> tmc_mcycle_div.sv
/*
  machine cycle divider: one-cycle enable every DIV cpu clocks.
  assumes the cpu clock is the only clock of the block.
*/
`timescale 1ns/1ps
`default_nettype none

module tmc_mcycle_div
  import tmc_pkg::*;
#(
  parameter int DIV = TMC_MC_CLKS
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // machine cycle enable
  output var  logic tick
);

  localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] div_reg;

  // ==========================================================
  // cycle counter and tick pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_reg <= '0;
      tick    <= 1'b0;
    end else begin
      div_reg <= (div_reg == LAST) ? '0 : div_reg + CW'(1);
      tick    <= (div_reg == LAST);
    end
  end

endmodule

`default_nettype wire

// >>> tmc_pin_sampler.sv
/*
  count pin sampler: two-flop synchroniser, one sample per machine
  cycle, falling edge taken from two successive samples.
  assumes the pin is asynchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none

module tmc_pin_sampler
  import tmc_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // machine cycle enable
  input  wire logic tick,
  // raw pin level
  input  wire logic pin_async,
  // one-cycle pulse after a sampled high-to-low step
  output var  logic fall
);

  logic sync1_reg;
  logic sync2_reg;
  logic sample_reg;

  // ==========================================================
  // synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= TMC_PIN_RST;
      sync2_reg <= TMC_PIN_RST;
    end else begin
      sync1_reg <= pin_async;
      sync2_reg <= sync1_reg;
    end
  end

  // ==========================================================
  // sample once a machine cycle, compare with the previous sample
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sample_reg <= TMC_PIN_RST;
      fall       <= 1'b0;
    end else begin
      if (tick) begin
        sample_reg <= sync2_reg;
      end
      fall <= tick & sample_reg & ~sync2_reg;
    end
  end

endmodule

`default_nettype wire

// >>> tmc_dual_timer.sv
/*
  dual 16-bit timer/counter with modes 0, 1, 2, 3 and 6, overflow
  flags, pin toggle output and a baud tick for the serial port.
  assumes control ports come from logic on CLK; count pins are
  asynchronous and the pin pad resolves level from OUT and OE.
*/
// Summary of operation
// - a machine cycle is two cpu clocks and paces both timers
// - timer function adds one to the count every machine cycle
// - counter function adds one on each falling edge of the pin
// - the count pin is sampled once a machine cycle, edges from samples
// - five modes 0, 1, 2, 3, 6; only mode 3 differs per timer
// - mode 0 is an 8-bit counter behind a divide-by-32 prescaler
// - mode 1 is mode 0 using all sixteen count bits
// - mode 2 is an 8-bit counter reloaded on every overflow
// - timer 1 in mode 3 stops counting
// - timer 1 in mode 3 still feeds the serial baud tick
// - timer 0 in mode 3 splits into two separate 8-bit counters
// - mode 6 is a pwm with a period of 256 timer clocks
// - with toggle enabled the pin inverts on every overflow outside mode 6 after the enabling cycle
// - toggle output shares the pin used as count input
// - enabling toggle outside mode 6 drives the pin high until the first overflow
`timescale 1ns/1ps
`default_nettype none

module tmc_dual_timer
  import tmc_pkg::*;
(
  // clock and reset
  input  wire logic         CLK,
  input  wire logic         RST,
  // per-timer configuration
  input  wire tmc_ctrl_type T0_CTRL,
  input  wire tmc_ctrl_type T1_CTRL,
  // software writes of the count registers
  input  wire tmc_load_type T0_LOAD,
  input  wire tmc_load_type T1_LOAD,
  // overflow flag clears
  input  wire logic         T0_FLAG_CLR,
  input  wire logic         T1_FLAG_CLR,
  // timer 0 pin
  input  wire logic         TIMER_ZERO_PIN_IN,
  output var  logic         TIMER_ZERO_PIN_OUT,
  output var  logic         TIMER_ZERO_PIN_OE,
  // timer 1 pin
  input  wire logic         TIMER_ONE_PIN_IN,
  output var  logic         TIMER_ONE_PIN_OUT,
  output var  logic         TIMER_ONE_PIN_OE,
  // state
  output var  logic [15:0]  T0_COUNT,
  output var  logic [15:0]  T1_COUNT,
  output var  logic         T0_OVF_FLAG,
  output var  logic         T1_OVF_FLAG,
  // serial port baud rate tick
  output var  logic         BAUD_TICK
);

  tmc_ctrl_type ctrl      [TMC_TIMERS];
  tmc_load_type load      [TMC_TIMERS];
  logic         flag_clr  [TMC_TIMERS];
  logic         pin_in    [TMC_TIMERS];
  logic         pin_fall  [TMC_TIMERS];
  logic         inc       [TMC_TIMERS];
  logic         ovf       [TMC_TIMERS];
  logic         hi_ovf    [TMC_TIMERS];
  logic         flag_set  [TMC_TIMERS];
  logic [15:0]  count_reg [TMC_TIMERS];
  logic [15:0]  count_next[TMC_TIMERS];
  logic         flag_reg  [TMC_TIMERS];
  logic         out_reg   [TMC_TIMERS];
  logic         oe_reg    [TMC_TIMERS];
  logic         ten_prev_reg[TMC_TIMERS];
  logic         mc_tick;
  logic         t0_split;
  logic         t1_halt;
  logic         hi_inc;
  logic [7:0]   baud_reg;
  logic         baud_out_reg;

  // ==========================================================
  // port grouping
  assign ctrl[0]     = T0_CTRL;
  assign ctrl[1]     = T1_CTRL;
  assign load[0]     = T0_LOAD;
  assign load[1]     = T1_LOAD;
  assign flag_clr[0] = T0_FLAG_CLR;
  assign flag_clr[1] = T1_FLAG_CLR;
  assign pin_in[0]   = TIMER_ZERO_PIN_IN;
  assign pin_in[1]   = TIMER_ONE_PIN_IN;
  assign t0_split    = (ctrl[0].mode == TMC_MODE_SPLIT);
  assign t1_halt     = (ctrl[1].mode == TMC_MODE_SPLIT);
  // upper half of split timer 0 borrows timer 1 run
  assign hi_inc      = ctrl[1].run & mc_tick;

  // ==========================================================
  // machine cycle base
  tmc_mcycle_div #(
    .DIV (TMC_MC_CLKS)
  ) u_div (
    .clk  (CLK),
    .rst  (RST),
    .tick (mc_tick)
  );

  // ==========================================================
  // per-timer counting, flag and pin logic
  for (genvar i = 0; i < TMC_TIMERS; i++) begin : g_tmr
    tmc_pin_sampler u_samp (
      .clk       (CLK),
      .rst       (RST),
      .tick      (mc_tick),
      .pin_async (pin_in[i]),
      .fall      (pin_fall[i])
    );

    // count enable: machine cycles or sampled pin falls
    assign inc[i] = ctrl[i].run & (ctrl[i].counter_sel ? pin_fall[i] : mc_tick);

    // flag source; split timer 0 upper half owns timer 1 flag
    assign flag_set[i] = (i == 0) ? ovf[0] : (t0_split ? hi_ovf[0] : ovf[1]);

    // next count per mode
    always_comb begin
      count_next[i] = count_reg[i];
      ovf[i]        = 1'b0;
      hi_ovf[i]     = 1'b0;
      unique case (ctrl[i].mode)
        TMC_MODE_13BIT: begin
          if (inc[i]) begin
            if (count_reg[i][4:0] == TMC_PRESC_MAX) begin
              count_next[i][4:0]  = 5'h00;
              count_next[i][15:8] = count_reg[i][15:8] + 8'h01;
              ovf[i]              = (count_reg[i][15:8] == TMC_BYTE_MAX);
            end else begin
              count_next[i][4:0] = count_reg[i][4:0] + 5'h01;
            end
          end
        end
        TMC_MODE_16BIT: begin
          if (inc[i]) begin
            count_next[i] = count_reg[i] + 16'h0001;
            ovf[i]        = (count_reg[i] == TMC_WORD_MAX);
          end
        end
        TMC_MODE_RELOAD: begin
          if (inc[i]) begin
            ovf[i] = (count_reg[i][7:0] == TMC_BYTE_MAX);
            count_next[i][7:0] = ovf[i] ? count_reg[i][15:8]
                                        : count_reg[i][7:0] + 8'h01;
          end
        end
        TMC_MODE_SPLIT: begin
          if (i == 0) begin
            if (inc[i]) begin
              count_next[i][7:0] = count_reg[i][7:0] + 8'h01;
              ovf[i]             = (count_reg[i][7:0] == TMC_BYTE_MAX);
            end
            if (hi_inc) begin
              count_next[i][15:8] = count_reg[i][15:8] + 8'h01;
              hi_ovf[i]           = (count_reg[i][15:8] == TMC_BYTE_MAX);
            end
          end
          // timer 1 holds its count here
        end
        TMC_MODE_PWM: begin
          if (inc[i]) begin
            count_next[i][7:0] = count_reg[i][7:0] + 8'h01;
            ovf[i]             = (count_reg[i][7:0] == TMC_BYTE_MAX);
          end
        end
        default: begin
          // unused mode codes hold the count
        end
      endcase
      // a software write replaces any count step
      if (load[i].stb) begin
        count_next[i] = load[i].value;
        ovf[i]        = 1'b0;
        hi_ovf[i]     = 1'b0;
      end
    end

    // count register
    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        count_reg[i] <= TMC_COUNT_RST;
      end else begin
        count_reg[i] <= count_next[i];
      end
    end

    // overflow flag; a set in the clearing cycle wins
    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        flag_reg[i] <= TMC_FLAG_RST;
      end else if (flag_set[i]) begin
        flag_reg[i] <= 1'b1;
      end else if (flag_clr[i]) begin
        flag_reg[i] <= 1'b0;
      end
    end

    // pin drive: toggle output or pwm level
    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        out_reg[i]      <= TMC_PIN_RST;
        oe_reg[i]       <= TMC_OE_RST;
        ten_prev_reg[i] <= 1'b0;
      end else begin
        ten_prev_reg[i] <= ctrl[i].toggle_en;
        oe_reg[i]       <= ctrl[i].toggle_en | (ctrl[i].mode == TMC_MODE_PWM);
        if (ctrl[i].mode == TMC_MODE_PWM) begin
          out_reg[i] <= (count_next[i][7:0] < count_next[i][15:8]);
        end else if (ctrl[i].toggle_en & ~ten_prev_reg[i]) begin
          out_reg[i] <= 1'b1;
        end else if (ctrl[i].toggle_en & ovf[i]) begin
          out_reg[i] <= ~out_reg[i];
        end
      end
    end
  end

  // ==========================================================
  // baud tick: timer 1 overflows, or a hidden reload counter when halted
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      baud_reg     <= TMC_BAUD_RST;
      baud_out_reg <= 1'b0;
    end else if (t1_halt) begin
      baud_out_reg <= 1'b0;
      if (ctrl[1].run & mc_tick) begin
        baud_reg     <= (baud_reg == TMC_BYTE_MAX) ? count_reg[1][15:8]
                                                   : baud_reg + 8'h01;
        baud_out_reg <= (baud_reg == TMC_BYTE_MAX);
      end
    end else begin
      baud_reg     <= count_reg[1][15:8];
      baud_out_reg <= ovf[1];
    end
  end

  // ==========================================================
  // outputs
  assign T0_COUNT           = count_reg[0];
  assign T1_COUNT           = count_reg[1];
  assign T0_OVF_FLAG        = flag_reg[0];
  assign T1_OVF_FLAG        = flag_reg[1];
  assign TIMER_ZERO_PIN_OUT = out_reg[0];
  assign TIMER_ZERO_PIN_OE  = oe_reg[0];
  assign TIMER_ONE_PIN_OUT  = out_reg[1];
  assign TIMER_ONE_PIN_OE   = oe_reg[1];
  assign BAUD_TICK          = baud_out_reg;

  // ==========================================================
  // assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  mcycle_two_clk_a: assert property (mc_tick |=> !mc_tick ##1 mc_tick)
    else $error("machine cycle tick not every two clocks");

  timer_step_a: assert property (T0_CTRL.run && !T0_CTRL.counter_sel
      && T0_CTRL.mode == TMC_MODE_16BIT && mc_tick && !T0_LOAD.stb
      |=> T0_COUNT == $past(T0_COUNT) + 16'h0001)
    else $error("timer function did not step once");

  counter_edge_a: assert property (T1_CTRL.run && T1_CTRL.counter_sel
      && T1_CTRL.mode == TMC_MODE_16BIT && !T1_LOAD.stb
      && !pin_fall[1] |=> T1_COUNT == $past(T1_COUNT))
    else $error("counter moved without a pin fall");

  sample_tick_a: assert property (pin_fall[0] |-> $past(mc_tick))
    else $error("pin edge taken outside a machine cycle sample");

  presc_upper_a: assert property (T0_CTRL.mode == TMC_MODE_13BIT
      && !T0_LOAD.stb |=> T0_COUNT[7:5] == $past(T0_COUNT[7:5]))
    else $error("mode 0 touched unused prescaler bits");

  reload_low_a: assert property (T0_CTRL.mode == TMC_MODE_RELOAD && inc[0]
      && T0_COUNT[7:0] == TMC_BYTE_MAX && !T0_LOAD.stb
      |=> T0_COUNT[7:0] == T0_COUNT[15:8] && T0_OVF_FLAG)
    else $error("mode 2 overflow did not reload");

  reload_keep_a: assert property (T1_CTRL.mode == TMC_MODE_RELOAD
      && !T1_LOAD.stb |=> $stable(T1_COUNT[15:8]))
    else $error("mode 2 reload byte changed");

  t1_stopped_a: assert property (T1_CTRL.mode == TMC_MODE_SPLIT
      && !T1_LOAD.stb |=> $stable(T1_COUNT))
    else $error("timer 1 counted in mode 3");

  split_hi_a: assert property (t0_split && hi_inc && !T0_LOAD.stb
      |=> T0_COUNT[15:8] == $past(T0_COUNT[15:8]) + 8'h01)
    else $error("split upper half did not step");

  // the bench turns toggle output on for timer 1, so watch that pin
  toggle_start_a: assert property ($rose(T1_CTRL.toggle_en)
      && T1_CTRL.mode != TMC_MODE_PWM |=> TIMER_ONE_PIN_OUT
      && TIMER_ONE_PIN_OE)
    else $error("toggle output not high on enable");

  toggle_ovf_a: assert property (T1_CTRL.toggle_en && ten_prev_reg[1]
      && ovf[1] && T1_CTRL.mode != TMC_MODE_PWM
      |=> TIMER_ONE_PIN_OUT != $past(TIMER_ONE_PIN_OUT))
    else $error("pin did not invert on overflow");

  flag_win_a: assert property (ovf[0] |=> T0_OVF_FLAG)
    else $error("overflow flag not set");

  pwm_wrap_c: cover property (T0_CTRL.mode == TMC_MODE_PWM && ovf[0]);
  split_c:    cover property (t0_split && hi_ovf[0] ##1 T1_OVF_FLAG);
  baud_c:     cover property (t1_halt && BAUD_TICK);
  count_c:    cover property (T1_CTRL.counter_sel && pin_fall[1] && inc[1]);

endmodule

`default_nettype wire

// >>> tmc_pin_source.sv
/*
  count pin event source: sends a burst of falling edges on request.
  assumes a pull-up on the pin, so the released level is high.
*/
`timescale 1ns/1ps
`default_nettype none

module tmc_pin_source
  import tmc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // burst request
  input  wire logic       start,
  input  wire logic [7:0] pulses,
  // released pin level and state
  output var  logic       src,
  output var  logic       busy
);
  // ==========================================================
  // burst engine
  logic [7:0] left_reg;
  logic [2:0] phase_reg;

  // low four clocks then high four, each level spans two machine cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      left_reg  <= 8'h00;
      phase_reg <= 3'h0;
      src       <= TMC_PIN_RST;
    end else if (start && left_reg == 8'h00) begin
      left_reg  <= pulses;
      phase_reg <= 3'h0;
    end else if (left_reg != 8'h00) begin
      phase_reg <= phase_reg + 3'h1;
      src       <= (phase_reg < 3'h4) ? 1'b0 : 1'b1;
      if (phase_reg == 3'h7)
        left_reg <= left_reg - 8'h01;
    end
  end

  // busy while edges remain
  assign busy = (left_reg != 8'h00);
endmodule

`default_nettype wire

// >>> tmc_dual_timer_tb.sv
/*
  self-checking bench of the dual timer/counter.
  assumes the pad resolves each pin from OE, OUT and the event source or pull-up.
*/
`timescale 1ns/1ps
`default_nettype none

module tmc_dual_timer_tb
  import tmc_pkg::*;
;
  // ==========================================================
  // signals
  logic         clk;
  logic         rst;
  tmc_ctrl_type ctrl [2];
  tmc_load_type ld   [2];
  logic         fclr [2];
  logic         go;
  wire  logic   src, busy, pin1, baud;
  wire  logic [15:0] cnt [2];
  wire  logic   out [2], oe [2], flag [2];
  int           err_total, tests_run, baud_n, hi_n, k;
  logic [15:0]  s;

  // pads: the timer drives when enabled, else the source or pull-up
  assign pin1 = oe[1] ? out[1] : src;

  tmc_dual_timer uut (
    .CLK(clk), .RST(rst), .T0_CTRL(ctrl[0]), .T1_CTRL(ctrl[1]),
    .T0_LOAD(ld[0]), .T1_LOAD(ld[1]), .T0_FLAG_CLR(fclr[0]), .T1_FLAG_CLR(fclr[1]),
    .TIMER_ZERO_PIN_IN(oe[0] ? out[0] : 1'b1), .TIMER_ZERO_PIN_OUT(out[0]),
    .TIMER_ZERO_PIN_OE(oe[0]), .TIMER_ONE_PIN_IN(pin1), .TIMER_ONE_PIN_OUT(out[1]),
    .TIMER_ONE_PIN_OE(oe[1]), .T0_COUNT(cnt[0]), .T1_COUNT(cnt[1]),
    .T0_OVF_FLAG(flag[0]), .T1_OVF_FLAG(flag[1]), .BAUD_TICK(baud));

  tmc_pin_source src_model (
    .clk(clk), .rst(rst), .start(go), .pulses(8'h03), .src(src), .busy(busy));

  // ==========================================================
  // clock, baud pulse counter, watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (baud === 1'b1)
      baud_n++;
  end

  initial begin
    #200000;
    err_total++;
    conclude();
  end

  // ==========================================================
  // tasks
  task automatic conclude();
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t bit %b expected %b", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic setc(input int i, input logic r, input logic c, input logic [2:0] m,
                      input logic t);
    // applied at this falling edge; the caller samples before the next step
    ctrl[i] = '{r, c, m, t};
  endtask

  // count write and flag clear, each a one-cycle pulse
  task automatic load(input int i, input logic [15:0] v);
    ld[i] = '{1'b1, v};
    fclr[i] = 1'b1;
    cyc(1);
    ld[i].stb = 1'b0;
    fclr[i] = 1'b0;
    cyc(1);
  endtask

  task automatic wait_step(input int i);
    int n;
    s = cnt[i];
    n = 0;
    while (cnt[i] === s && n < 600) begin
      cyc(1);
      n++;
    end
    chk1(n < 600, 1'b1);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    go = 1'b0;
    err_total = 0;
    tests_run = 0;
    baud_n = 0;
    for (int i = 0; i < 2; i++) begin
      ctrl[i] = '{1'b0, 1'b0, TMC_MODE_16BIT, 1'b0};
      ld[i] = '{1'b0, 16'h0000};
      fclr[i] = 1'b0;
    end
    cyc(10);
    rst = 1'b0;
    cyc(1);
    chk16(cnt[0], TMC_COUNT_RST);
    chk1(out[1], 1'b1);
    chk1(oe[1], 1'b0);
    chk1(flag[0], 1'b0);
    // mode 1 wrap and rate
    load(0, 16'hfffe);
    setc(0, 1, 0, TMC_MODE_16BIT, 0);
    wait_step(0);
    chk16(cnt[0], 16'hffff);
    chk1(flag[0], 1'b0);
    wait_step(0);
    chk16(cnt[0], 16'h0000);
    chk1(flag[0], 1'b1);
    s = cnt[0];
    cyc(20);
    chk16(cnt[0] - s, 16'h000a);
    setc(0, 0, 0, TMC_MODE_16BIT, 0);
    fclr[0] = 1'b1;
    cyc(1);
    fclr[0] = 1'b0;
    cyc(1);
    chk1(flag[0], 1'b0);
    // mode 0 prescaler carry, bits 7:5 left alone
    load(0, 16'h00bf);
    setc(0, 1, 0, TMC_MODE_13BIT, 0);
    wait_step(0);
    chk16(cnt[0], 16'h01a0);
    setc(0, 0, 0, TMC_MODE_13BIT, 0);
    load(0, 16'hffbf);
    setc(0, 1, 0, TMC_MODE_13BIT, 0);
    wait_step(0);
    chk16(cnt[0], 16'h00a0);
    chk1(flag[0], 1'b1);
    // mode 2 reload from the high byte
    setc(0, 0, 0, TMC_MODE_RELOAD, 0);
    load(0, 16'h80fe);
    setc(0, 1, 0, TMC_MODE_RELOAD, 0);
    wait_step(0);
    wait_step(0);
    chk16(cnt[0], 16'h8080);
    chk1(flag[0], 1'b1);
    // an unused mode code holds the count
    setc(0, 1, 0, 3'h4, 0);
    s = cnt[0];
    cyc(10);
    chk16(cnt[0], s);
    // counter function on the timer 1 pin
    setc(0, 0, 0, TMC_MODE_16BIT, 0);
    load(1, 16'h0000);
    setc(1, 1, 1, TMC_MODE_16BIT, 0);
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    while (busy === 1'b1)
      cyc(1);
    cyc(10);
    chk16(cnt[1], 16'h0003);
    // toggle output on the timer 1 pin
    setc(1, 0, 0, TMC_MODE_RELOAD, 1);
    load(1, 16'hf0fe);
    chk1(out[1], 1'b1);
    chk1(oe[1], 1'b1);
    k = baud_n;
    setc(1, 1, 0, TMC_MODE_RELOAD, 1);
    wait_step(1);
    chk1(pin1, 1'b1);
    wait_step(1);
    chk1(pin1, 1'b0);
    cyc(2);
    chk16(16'(baud_n - k), 16'h0001);
    repeat (16) wait_step(1);
    chk1(pin1, 1'b1);
    // timer 1 in mode 3: frozen, baud still ticks
    setc(1, 1, 0, TMC_MODE_SPLIT, 0);
    s = cnt[1];
    k = baud_n;
    cyc(100);
    chk16(cnt[1], s);
    chk1(baud_n > k, 1'b1);
    // timer 0 in mode 3: two separate bytes
    setc(1, 0, 0, TMC_MODE_SPLIT, 0);
    setc(0, 0, 0, TMC_MODE_SPLIT, 0);
    load(0, 16'hfe05);
    load(1, cnt[1]);
    setc(1, 1, 0, TMC_MODE_SPLIT, 0);
    cyc(10);
    chk16(cnt[0] & 16'h00ff, 16'h0005);
    chk1(flag[1], 1'b1);
    setc(1, 0, 0, TMC_MODE_SPLIT, 0);
    setc(0, 1, 0, TMC_MODE_SPLIT, 0);
    s = cnt[0];
    wait_step(0);
    chk16(cnt[0], {s[15:8], 8'h06});
    // mode 6 duty over one whole period
    setc(0, 0, 0, TMC_MODE_PWM, 0);
    load(0, 16'h4000);
    setc(0, 1, 0, TMC_MODE_PWM, 0);
    chk1(oe[0], 1'b1);
    hi_n = 0;
    for (int n = 0; n < 2 * TMC_PWM_COUNT; n++) begin
      if (out[0] === 1'b1)
        hi_n++;
      cyc(1);
    end
    chk16(16'(hi_n), 16'h0080);
    conclude();
  end
endmodule

`default_nettype wire
